// ### hdl/paw_pkg.sv
// Constants for the program address pointer and window register block.
// Assumes a single core clock domain; shared by the top and its table fetch leaf.
package paw_pkg;

    // System register nibble addresses, most significant nibble lowest
    localparam int              PAW_SYS_AW      = 7;
    localparam logic [6:0]      PAW_ADDR_TOP    = 7'h74;
    localparam logic [6:0]      PAW_ADDR_UPPER  = 7'h75;
    localparam logic [6:0]      PAW_ADDR_LOWER  = 7'h76;
    localparam logic [6:0]      PAW_ADDR_BOTTOM = 7'h77;
    localparam logic [6:0]      PAW_ADDR_WINDOW = 7'h78;

    // Widths
    localparam int              PAW_NIB_W       = 4;
    localparam int              PAW_PTR_W       = 16;
    localparam int              PAW_CBUF_W      = 16;
    localparam int              PAW_RF_AW       = 7;

    // Nibble field positions inside the pointer (low bit of each)
    localparam int              PAW_TOP_LSB     = 12;
    localparam int              PAW_UPPER_LSB   = 8;
    localparam int              PAW_LOWER_LSB   = 4;
    localparam int              PAW_BOTTOM_LSB  = 0;

    // Effective pointer widths of the two memory variants
    localparam int              PAW_BITS_SMALL  = 8;
    localparam int              PAW_BITS_LARGE  = 13;

    // Reset values and the increment step
    localparam logic [15:0]     PAW_PTR_RST     = 16'h0000;
    localparam logic [3:0]      PAW_WIN_RST     = 4'h0;
    localparam logic [3:0]      PAW_NIB_ZERO    = 4'h0;
    localparam logic [15:0]     PAW_PTR_ONE     = 16'h0001;

    // Address stack defaults
    localparam int              PAW_STACK_DEPTH = 5;

    // Table fetch sequencer
    typedef enum logic {
        PAW_FETCH_IDLE,
        PAW_FETCH_WAIT
    } paw_fetch_e;

endpackage : paw_pkg

// ### hdl/paw_stack_mem.sv
// Address stack storage: one write port, one read port with registered data.
// Assumes the caller keeps both addresses below DEPTH.
`timescale 1ns/1ns
`default_nettype none
module paw_stack_mem #(
    parameter int DEPTH = 5,
    parameter int AW    = 3,
    parameter int DW    = 16
) (
    input  wire logic          core_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [DW-1:0] rd_data_r
);
    logic [DW-1:0] mem [DEPTH];

    generate
        if ((1 << AW) < DEPTH) begin : g_bad_aw
            $error("paw_stack_mem: address too narrow for depth");
        end
    endgenerate

    // Entries carry no reset; software never pops what it did not push
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data comes from a register, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (rd_en) begin
            rd_data_r <= mem[rd_addr];
        end
    end
endmodule // paw_stack_mem
`default_nettype wire

// ### hdl/paw_table_fetch.sv
// Table fetch sequencer: reads one 16-bit constant word from program memory.
// Assumes program memory returns data in the same cycle as its read strobe.
`timescale 1ns/1ns
`default_nettype none
module paw_table_fetch
    import paw_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  wire logic [PAW_PTR_W-1:0]  addr,
    output var  logic                  pm_rd_en_r,
    output var  logic [PAW_PTR_W-1:0]  pm_addr_r,
    input  wire logic [PAW_CBUF_W-1:0] pm_rdata,
    output var  logic [PAW_CBUF_W-1:0] cbuf_r,
    output var  logic                  cbuf_valid_r,
    output logic                       busy
);
    paw_fetch_e state_r;

    assign busy = (state_r == PAW_FETCH_WAIT);

    // Two-step sequence: strobe the address, then capture the word
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r      <= PAW_FETCH_IDLE;
            pm_rd_en_r   <= 1'b0;
            pm_addr_r    <= PAW_PTR_RST;
            cbuf_valid_r <= 1'b0;
        end else begin
            pm_rd_en_r   <= 1'b0;
            cbuf_valid_r <= 1'b0;
            unique case (state_r)
                PAW_FETCH_IDLE: begin
                    if (start) begin
                        pm_rd_en_r <= 1'b1;
                        pm_addr_r  <= addr;
                        state_r    <= PAW_FETCH_WAIT;
                    end
                end
                PAW_FETCH_WAIT: begin
                    cbuf_valid_r <= 1'b1;
                    state_r      <= PAW_FETCH_IDLE;
                end
            endcase
        end
    end

    // Constant buffer keeps the last fetched word
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cbuf_r <= '0;
        end else if (state_r == PAW_FETCH_WAIT) begin
            cbuf_r <= pm_rdata;
        end
    end
endmodule // paw_table_fetch
`default_nettype wire

// ### hdl/paw_regs.sv
// Program address pointer and file transfer window registers of a 4-bit core.
// Assumes the instruction sequencer issues at most one operation pulse per
// cycle, all on core_clk, and owns the register file and program memory.
//
// Operation
// - The pointer is 16 bits seen as four nibbles at 74H..77H, top nibble at 74H.
// - Upper 8 bits (small variant) or upper 3 bits (large) read zero and ignore writes.
// - A table fetch reads the 16-bit program word at the pointer into the constant buffer.
// - A push decrements the stack pointer, then stores the pointer at the new entry.
// - A pop loads the pointer from the current entry, then increments the stack pointer.
// - An indirect jump sends execution to the address held in the pointer.
// - An indirect call starts the subroutine at the address held in the pointer.
// - Increment adds one; the small variant wraps from 00FFH to 0000H.
// - The large variant has 13 bits and wraps from 1FFFH to 0000H.
// - The pointer is also read and written whole through the data buffer path.
// - A 4-bit window register sits at system address 78H.
// - A array_to_window_op copies the addressed register array nibble into the window.
// - A window_to_array_op copies the window into the addressed register array nibble.
`timescale 1ns/1ns
`default_nettype none
module paw_regs
    import paw_pkg::*;
#(
    parameter int PTR_BITS    = PAW_BITS_LARGE,
    parameter int STACK_DEPTH = PAW_STACK_DEPTH,
    parameter int SP_W        = 3
) (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic                         clk_stop_clr,
    input  wire logic                         ce_clr,
    input  wire logic                         sys_wr_en,
    input  wire logic                         sys_rd_en,
    input  wire logic [paw_pkg::PAW_SYS_AW-1:0] sys_addr,
    input  wire logic [paw_pkg::PAW_NIB_W-1:0]  sys_wdata,
    output var  logic [paw_pkg::PAW_NIB_W-1:0]  sys_rdata_r,
    output var  logic                         sys_hit_r,
    input  wire logic                         dbuf_ptr_wr,
    input  wire logic [paw_pkg::PAW_PTR_W-1:0]  dbuf_wdata,
    output var  logic [paw_pkg::PAW_PTR_W-1:0]  program_address_pointer_r,
    input  wire logic                         table_fetch_op,
    output var  logic                         pm_rd_en_r,
    output var  logic [paw_pkg::PAW_PTR_W-1:0]  pm_addr_r,
    input  wire logic [paw_pkg::PAW_CBUF_W-1:0] pm_rdata,
    output var  logic [paw_pkg::PAW_CBUF_W-1:0] constant_buffer_r,
    output var  logic                         constant_buffer_valid_r,
    output logic                              fetch_busy,
    input  wire logic                         push_op,
    input  wire logic                         pop_op,
    output var  logic [SP_W-1:0]              stack_ptr_r,
    input  wire logic                         inc_op,
    input  wire logic                         indirect_jump_op,
    input  wire logic                         indirect_call_op,
    output var  logic [paw_pkg::PAW_PTR_W-1:0]  branch_target_r,
    output var  logic                         jump_valid_r,
    output var  logic                         call_valid_r,
    input  wire logic                         array_to_window_op,
    input  wire logic                         window_to_array_op,
    input  wire logic [paw_pkg::PAW_RF_AW-1:0]  rf_operand,
    output var  logic [paw_pkg::PAW_RF_AW-1:0]  rf_addr_r,
    output var  logic                         rf_rd_en_r,
    input  wire logic [paw_pkg::PAW_NIB_W-1:0]  rf_rdata,
    output var  logic                         rf_wr_en_r,
    output var  logic [paw_pkg::PAW_NIB_W-1:0]  rf_wdata_r,
    output var  logic [paw_pkg::PAW_NIB_W-1:0]  file_transfer_window_r
);
    import paw_pkg::*;

    // Only the two documented variants have a defined fixed-zero field
    generate
        if (PTR_BITS != PAW_BITS_SMALL && PTR_BITS != PAW_BITS_LARGE) begin : g_bad_bits
            $error("paw_regs: PTR_BITS must be 8 or 13");
        end
        if ((1 << SP_W) < STACK_DEPTH + 1) begin : g_bad_sp
            $error("paw_regs: SP_W too narrow for STACK_DEPTH");
        end
    endgenerate

    // Bits above the effective width are held at zero
    localparam logic [PAW_PTR_W-1:0] PTR_MASK =
        PAW_PTR_W'((32'h1 << PTR_BITS) - 32'h1);
    localparam logic [SP_W-1:0]      SP_EMPTY = SP_W'(STACK_DEPTH);
    localparam logic [SP_W-1:0]      SP_ONE   = SP_W'(1);

    logic [PAW_PTR_W-1:0] ptr_nxt;
    logic [PAW_PTR_W-1:0] sys_wr_ptr;
    logic [PAW_PTR_W-1:0] stack_rd_data;
    logic [SP_W-1:0]      sp_dec;
    logic                 pop_wait_r;
    logic                 any_clr;

    assign any_clr = clk_stop_clr || ce_clr;
    assign sp_dec  = stack_ptr_r - SP_ONE;

    // Pointer image with one nibble replaced by a system register write
    always_comb begin
        sys_wr_ptr = program_address_pointer_r;
        unique case (sys_addr)
            PAW_ADDR_TOP:    sys_wr_ptr[PAW_TOP_LSB    +: PAW_NIB_W] = sys_wdata;
            PAW_ADDR_UPPER:  sys_wr_ptr[PAW_UPPER_LSB  +: PAW_NIB_W] = sys_wdata;
            PAW_ADDR_LOWER:  sys_wr_ptr[PAW_LOWER_LSB  +: PAW_NIB_W] = sys_wdata;
            PAW_ADDR_BOTTOM: sys_wr_ptr[PAW_BOTTOM_LSB +: PAW_NIB_W] = sys_wdata;
            default:         sys_wr_ptr = program_address_pointer_r;
        endcase
    end

    // Next pointer value; resets first, then whole-word loads, then increment.
    // Every load passes the mask so the fixed bits can never be set.
    always_comb begin
        ptr_nxt = program_address_pointer_r;
        if (any_clr) begin
            ptr_nxt = PAW_PTR_RST;
        end else if (dbuf_ptr_wr) begin
            ptr_nxt = dbuf_wdata & PTR_MASK;
        end else if (sys_wr_en) begin
            ptr_nxt = sys_wr_ptr & PTR_MASK;
        end else if (pop_wait_r) begin
            ptr_nxt = stack_rd_data & PTR_MASK;
        end else if (inc_op) begin
            ptr_nxt = (program_address_pointer_r + PAW_PTR_ONE) & PTR_MASK;
        end
    end

    // Pointer register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            program_address_pointer_r <= PAW_PTR_RST;
        end else begin
            program_address_pointer_r <= ptr_nxt;
        end
    end

    // Stack pointer: decrement before a push, increment after a pop lands.
    // Cleared alongside the pointer so a restarted program sees an empty stack.
    always_ff @(posedge core_clk) begin
        if (!rst_n || any_clr) begin
            stack_ptr_r <= SP_EMPTY;
        end else if (push_op) begin
            stack_ptr_r <= sp_dec;
        end else if (pop_wait_r) begin
            stack_ptr_r <= stack_ptr_r + SP_ONE;
        end
    end

    // Pop is two cycles because the stack memory has registered read data
    always_ff @(posedge core_clk) begin
        if (!rst_n || any_clr) begin
            pop_wait_r <= 1'b0;
        end else begin
            pop_wait_r <= pop_op;
        end
    end

    // Address stack entries; push writes at the already decremented index
    paw_stack_mem #(
        .DEPTH     (STACK_DEPTH),
        .AW        (SP_W),
        .DW        (PAW_PTR_W)
    ) u_stack (
        .core_clk  (core_clk),
        .wr_en     (push_op),
        .wr_addr   (sp_dec),
        .wr_data   (program_address_pointer_r),
        .rd_en     (pop_op),
        .rd_addr   (stack_ptr_r),
        .rd_data_r (stack_rd_data)
    );

    // Table fetch through program memory into the constant buffer
    paw_table_fetch u_fetch (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .start        (table_fetch_op),
        .addr         (program_address_pointer_r),
        .pm_rd_en_r   (pm_rd_en_r),
        .pm_addr_r    (pm_addr_r),
        .pm_rdata     (pm_rdata),
        .cbuf_r       (constant_buffer_r),
        .cbuf_valid_r (constant_buffer_valid_r),
        .busy         (fetch_busy)
    );

    // Indirect branch and call targets; the sequencer loads its program counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            branch_target_r <= PAW_PTR_RST;
            jump_valid_r    <= 1'b0;
            call_valid_r    <= 1'b0;
        end else begin
            jump_valid_r <= indirect_jump_op;
            call_valid_r <= indirect_call_op;
            if (indirect_jump_op || indirect_call_op) begin
                branch_target_r <= program_address_pointer_r;
            end
        end
    end

    // Register array strobes for array_to_window_op and window_to_array_op
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rf_addr_r  <= '0;
            rf_rd_en_r <= 1'b0;
            rf_wr_en_r <= 1'b0;
            rf_wdata_r <= PAW_WIN_RST;
        end else begin
            rf_rd_en_r <= array_to_window_op;
            rf_wr_en_r <= window_to_array_op;
            if (array_to_window_op || window_to_array_op) begin
                rf_addr_r <= rf_operand;
            end
            if (window_to_array_op) begin
                rf_wdata_r <= file_transfer_window_r;
            end
        end
    end

    // Window register; power-on gives a fixed value in place of an undefined
    // one, and the two soft resets leave it alone on purpose.
    // Array_to_window_op data stands only while the array read strobe does, so it is
    // taken on the edge that closes the strobe cycle, not one later.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            file_transfer_window_r <= PAW_WIN_RST;
        end else if (rf_rd_en_r) begin
            file_transfer_window_r <= rf_rdata;
        end else if (sys_wr_en && sys_addr == PAW_ADDR_WINDOW) begin
            file_transfer_window_r <= sys_wdata;
        end
    end

    // System register read port; unmapped addresses answer zero, hit low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sys_rdata_r <= PAW_NIB_ZERO;
            sys_hit_r   <= 1'b0;
        end else if (sys_rd_en) begin
            sys_hit_r <= 1'b1;
            unique case (sys_addr)
                PAW_ADDR_TOP:    sys_rdata_r <= program_address_pointer_r[PAW_TOP_LSB +: PAW_NIB_W];
                PAW_ADDR_UPPER:  sys_rdata_r <= program_address_pointer_r[PAW_UPPER_LSB +: PAW_NIB_W];
                PAW_ADDR_LOWER:  sys_rdata_r <= program_address_pointer_r[PAW_LOWER_LSB +: PAW_NIB_W];
                PAW_ADDR_BOTTOM: sys_rdata_r <= program_address_pointer_r[PAW_BOTTOM_LSB +: PAW_NIB_W];
                PAW_ADDR_WINDOW: sys_rdata_r <= file_transfer_window_r;
                default: begin
                    sys_rdata_r <= PAW_NIB_ZERO;
                    sys_hit_r   <= 1'b0;
                end
            endcase
        end else begin
            sys_hit_r <= 1'b0;
        end
    end

endmodule // paw_regs
`default_nettype wire

// ### test/paw_regs_properties.sv
// Timing checker for the pointer and window register block.
// Assumes it is bound to every paw_regs instance and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module paw_regs_checker
    import paw_pkg::*;
#(
    parameter int PTR_BITS    = PAW_BITS_LARGE,
    parameter int STACK_DEPTH = PAW_STACK_DEPTH,
    parameter int SP_W        = 3
) (
    input wire logic            core_clk, rst_n, clk_stop_clr, ce_clr, sys_wr_en,
    input wire logic            dbuf_ptr_wr, table_fetch_op, fetch_busy, pm_rd_en_r,
    input wire logic            constant_buffer_valid_r, push_op, pop_op, inc_op,
    input wire logic            indirect_jump_op, indirect_call_op, jump_valid_r,
    input wire logic            call_valid_r, array_to_window_op, rf_rd_en_r,
    input wire logic            window_to_array_op, rf_wr_en_r,
    input wire logic [15:0]     dbuf_wdata, program_address_pointer_r, pm_addr_r,
    input wire logic [15:0]     pm_rdata, constant_buffer_r, branch_target_r,
    input wire logic [SP_W-1:0] stack_ptr_r,
    input wire logic [3:0]      rf_rdata, rf_wdata_r, file_transfer_window_r
);
    // Bits above the variant's width must never be set
    localparam logic [15:0] MASK = 16'((32'h1 << PTR_BITS) - 1);
    logic clr;
    assign clr = clk_stop_clr || ce_clr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_fixed_zero_bits: assert property ((program_address_pointer_r & ~MASK) == 16'h0000)
        else $error("pointer has fixed-zero bits set");
    a_reset_clears_ptr: assert property (clr |=> program_address_pointer_r == 16'h0000
        && stack_ptr_r == SP_W'(STACK_DEPTH)) else $error("clear did not empty pointer");
    a_fetch_strobe: assert property (table_fetch_op && !fetch_busy |=> pm_rd_en_r
        && pm_addr_r == $past(program_address_pointer_r)) else $error("fetch strobe wrong");
    a_fetch_data_lands: assert property (pm_rd_en_r |=> constant_buffer_valid_r
        && constant_buffer_r == $past(pm_rdata)) else $error("fetched word wrong");
    a_push_moves_sp: assert property (push_op && !clr |=>
        (stack_ptr_r + 1'b1) == $past(stack_ptr_r)) else $error("push stack pointer wrong");
    a_pop_moves_sp: assert property (pop_op && !clr ##1 !clr |=>
        (stack_ptr_r - 1'b1) == $past(stack_ptr_r, 2)) else $error("pop stack pointer wrong");
    a_branch_target: assert property (indirect_jump_op || indirect_call_op |=>
        branch_target_r == $past(program_address_pointer_r) && jump_valid_r == $past(
        indirect_jump_op) && call_valid_r == $past(indirect_call_op)) else $error("target wrong");
    a_inc_wraps: assert property (inc_op && !clr && !dbuf_ptr_wr && !sys_wr_en
        && !$past(pop_op) |=> program_address_pointer_r == (($past(
        program_address_pointer_r) + 16'h0001) & MASK)) else $error("increment wrong");
    a_dbuf_load: assert property (dbuf_ptr_wr && !clr |=>
        program_address_pointer_r == ($past(dbuf_wdata) & MASK)) else $error("load wrong");
    a_array_to_window_op_path: assert property (array_to_window_op |=> rf_rd_en_r ##1
        file_transfer_window_r == $past(rf_rdata)) else $error("array_to_window_op wrong");
    a_window_to_array_op_path: assert property (window_to_array_op |=> rf_wr_en_r
        && rf_wdata_r == $past(file_transfer_window_r)) else $error("window_to_array_op wrong");
    a_window_holds: assert property (clr && !rf_rd_en_r && !sys_wr_en |=>
        $stable(file_transfer_window_r)) else $error("window lost on clear");

    c_wrap: cover property (inc_op && program_address_pointer_r == MASK);
    c_pop: cover property (pop_op ##2 1'b1);
    c_array_to_window_op: cover property (array_to_window_op);
endmodule // paw_regs_checker

bind paw_regs paw_regs_checker #(.PTR_BITS(PTR_BITS), .STACK_DEPTH(STACK_DEPTH),
    .SP_W(SP_W)) u_chk (.*);
`default_nettype wire

// ### test/paw_far_side_model.sv
// Far-side model: program memory and nibble register array.
// Assumes read data in the same cycle as the read strobe; idle data lines show changing noise.
`timescale 1ns/1ns
`default_nettype none
module paw_far_side_model (
    input  wire logic        core_clk,
    input  wire logic        pm_rd_en_r,
    input  wire logic [15:0] pm_addr_r,
    output logic      [15:0] pm_rdata,
    input  wire logic        rf_rd_en_r,
    input  wire logic        rf_wr_en_r,
    input  wire logic [6:0]  rf_addr_r,
    input  wire logic [3:0]  rf_wdata_r,
    output logic      [3:0]  rf_rdata
);
    logic [3:0] arr_r [128];
    logic [3:0] junk_r;
    // Known start pattern so a array_to_window_op has a predictable answer
    initial begin
        junk_r = 4'h0;
        foreach (arr_r[i]) arr_r[i] = 4'(i) ^ 4'ha;
    end
    always @(posedge core_clk) begin
        junk_r <= junk_r + 4'h7;
        if (rf_wr_en_r) arr_r[rf_addr_r] <= rf_wdata_r;
    end
    // Data only while a strobe stands, so a late sample sees noise
    assign pm_rdata = pm_rd_en_r ? (pm_addr_r ^ 16'hc3a5) : {4{junk_r}};
    assign rf_rdata = rf_rd_en_r ? arr_r[rf_addr_r] : ~junk_r;
endmodule // paw_far_side_model
`default_nettype wire

// ### test/test_paw_regs.sv
// Self-checking bench for the pointer and window register block.
// Assumes the far-side model answers memory and array reads.
`timescale 1ns/1ns
`default_nettype none
module test_paw_regs;
    import paw_pkg::*;
    localparam int CSTOP = 10, CE = 9, DBUF = 8, FETCH = 7, PUSH = 6, POP = 5;
    localparam int INC = 4, JUMP = 3, CALL = 2, ARRAY_TO_WINDOW_OP = 1, WINDOW_TO_ARRAY_OP = 0;
    logic        core_clk = 1'b0, rst_n = 1'b0, sys_wr_en, sys_rd_en, sys_hit_r;
    logic        clk_stop_clr, ce_clr, dbuf_ptr_wr, table_fetch_op, push_op, pop_op, inc_op;
    logic        indirect_jump_op, indirect_call_op, array_to_window_op, window_to_array_op;
    logic        pm_rd_en_r, constant_buffer_valid_r, fetch_busy, jump_valid_r, call_valid_r;
    logic        rf_rd_en_r, rf_wr_en_r;
    logic [10:0] ops;
    logic [6:0]  sys_addr, rf_operand, rf_addr_r;
    logic [3:0]  sys_wdata, sys_rdata_r, rf_rdata, rf_wdata_r, file_transfer_window_r;
    logic [15:0] dbuf_wdata, program_address_pointer_r, pm_addr_r, pm_rdata;
    logic [15:0] constant_buffer_r, branch_target_r, small_ptr;
    logic [2:0]  stack_ptr_r;
    int          fails = 0, total_checks = 0;

    assign {clk_stop_clr, ce_clr, dbuf_ptr_wr, table_fetch_op, push_op, pop_op, inc_op,
            indirect_jump_op, indirect_call_op, array_to_window_op, window_to_array_op} = ops;
    paw_regs dut (.*);
    paw_far_side_model u_far (.*);
    // Small variant on the same stimulus; only its pointer is compared
    paw_regs #(.PTR_BITS(PAW_BITS_SMALL)) dut_small (
        .core_clk(core_clk), .rst_n(rst_n), .clk_stop_clr(clk_stop_clr),
        .ce_clr(ce_clr), .sys_wr_en(sys_wr_en), .sys_rd_en(sys_rd_en),
        .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_rdata_r(), .sys_hit_r(),
        .dbuf_ptr_wr(dbuf_ptr_wr), .dbuf_wdata(dbuf_wdata),
        .program_address_pointer_r(small_ptr), .table_fetch_op(table_fetch_op),
        .pm_rd_en_r(), .pm_addr_r(), .pm_rdata(pm_rdata), .constant_buffer_r(),
        .constant_buffer_valid_r(), .fetch_busy(), .push_op(push_op), .pop_op(pop_op),
        .stack_ptr_r(), .inc_op(inc_op), .indirect_jump_op(indirect_jump_op),
        .indirect_call_op(indirect_call_op), .branch_target_r(), .jump_valid_r(),
        .call_valid_r(), .array_to_window_op(array_to_window_op),
        .window_to_array_op(window_to_array_op), .rf_operand(rf_operand),
        .rf_addr_r(), .rf_rd_en_r(), .rf_rdata(rf_rdata), .rf_wr_en_r(),
        .rf_wdata_r(), .file_transfer_window_r()
    );
    always #4 core_clk = ~core_clk;

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask
    // One-cycle operation pulse; the gap edge keeps drivers from clashing
    task automatic pulse(input int b);
        @(negedge core_clk);
        ops[b] = 1'b1;
        @(negedge core_clk);
        ops = '0;
    endtask
    task automatic sys(input logic we, input logic [6:0] a, input logic [3:0] d);
        @(negedge core_clk);
        {sys_wr_en, sys_rd_en, sys_addr, sys_wdata} = {we, !we, a, d};
        @(negedge core_clk);
        {sys_wr_en, sys_rd_en} = 2'b00;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        {ops, sys_wr_en, sys_rd_en, sys_addr, sys_wdata, dbuf_wdata, rf_operand} = '0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        chk_val(program_address_pointer_r, 16'h0000);
        // Nibble writes, top nibble lowest; fixed bits drop
        for (int i = 0; i < 4; i++) sys(1'b1, PAW_ADDR_TOP + 7'(i), 4'hf);
        chk_val(program_address_pointer_r, 16'h1fff);
        chk_val(small_ptr, 16'h00ff);
        for (int i = 0; i < 4; i++) begin
            sys(1'b0, PAW_ADDR_TOP + 7'(i), 4'h0);
            chk_val({12'h000, sys_rdata_r}, (16'h1fff >> (12 - 4 * i)) & 16'h000f);
            chk_flag(sys_hit_r, 1'b1);
        end
        sys(1'b0, 7'h7a, 4'h0);
        chk_flag(sys_hit_r, 1'b0);
        pulse(INC);
        chk_val(program_address_pointer_r, 16'h0000);
        chk_val(small_ptr, 16'h0000);
        dbuf_wdata = 16'hffff;
        pulse(DBUF);
        chk_val(program_address_pointer_r, 16'h1fff);
        dbuf_wdata = 16'h1234;
        pulse(DBUF);
        pulse(FETCH);
        chk_val(pm_addr_r, 16'h1234);
        chk_flag(fetch_busy, 1'b1);
        @(negedge core_clk);
        chk_val(constant_buffer_r, 16'h1234 ^ 16'hc3a5);
        pulse(JUMP);
        chk_val(branch_target_r, 16'h1234);
        chk_flag(jump_valid_r, 1'b1);
        pulse(CALL);
        chk_flag(call_valid_r, 1'b1);
        // Two pushes then two pops come back in reverse order
        pulse(PUSH);
        chk_val(16'(stack_ptr_r), 16'h0004);
        dbuf_wdata = 16'h0abc;
        pulse(DBUF);
        pulse(PUSH);
        pulse(INC);
        for (int i = 0; i < 2; i++) begin
            pulse(POP);
            repeat (2) @(negedge core_clk);
            chk_val(program_address_pointer_r, i ? 16'h1234 : 16'h0abc);
            chk_val(16'(stack_ptr_r), i ? 16'h0005 : 16'h0004);
        end
        sys(1'b1, PAW_ADDR_WINDOW, 4'h9);
        sys(1'b0, PAW_ADDR_WINDOW, 4'h0);
        chk_val({12'h000, sys_rdata_r}, 16'h0009);
        rf_operand = 7'h23;
        pulse(WINDOW_TO_ARRAY_OP);
        chk_val({12'h000, rf_wdata_r}, 16'h0009);
        chk_val({9'h000, rf_addr_r}, 16'h0023);
        for (int i = 0; i < 2; i++) begin
            rf_operand = i ? 7'h23 : 7'h15;
            pulse(ARRAY_TO_WINDOW_OP);
            @(negedge core_clk);
            chk_val({12'h000, file_transfer_window_r}, i ? 16'h0009 : 16'h000f);
        end
        // Both soft clears empty pointer and stack but keep the window
        for (int b = CE; b <= CSTOP; b++) begin
            pulse(PUSH);
            pulse(b);
            chk_val(program_address_pointer_r, 16'h0000);
            chk_val(16'(stack_ptr_r), 16'h0005);
            chk_val({12'h000, file_transfer_window_r}, 16'h0009);
            pulse(INC);
        end
        report_and_stop();
    end
    // The sequence needs under a hundred cycles; this cuts a hang short
    initial begin
        #(8 * 2000);
        fails++;
        report_and_stop();
    end
endmodule // test_paw_regs
`default_nettype wire
